// *** rtl/dioim_map.sv ***
// digital process image mapper for input and output modules
module dioim_map #(
    parameter int ANA_IN_BYTES = 1,
    parameter int ANA_OUT_BYTES = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dioim_pkg::dioim_pins_t pins,
    input wire logic [ANA_IN_BYTES*8-1:0] ana_in_data,
    output logic [(ANA_IN_BYTES+dioim_pkg::DIG_IN_BYTES)*8-1:0] in_image,
    input wire logic out_wr,
    input wire logic [(ANA_OUT_BYTES+dioim_pkg::DIG_OUT_BYTES)*8-1:0] out_image,
    output logic [ANA_OUT_BYTES*8-1:0] ana_out_data,
    output dioim_pkg::dioim_outs_t outs,
    output logic [7:0] inst_in_cnt,
    output logic [7:0] inst_out_cnt
);
    import dioim_pkg::*;

    localparam int NPIN = $bits(dioim_pins_t);
    localparam int DIB = ANA_IN_BYTES * 8;
    localparam int DOB = ANA_OUT_BYTES * 8;
    localparam int IMG_IN_W = (ANA_IN_BYTES + DIG_IN_BYTES) * 8;

    if (ANA_IN_BYTES < 1 || ANA_OUT_BYTES < 1) begin : g_bad_size
        $error("analog areas must hold at least one byte");
    end

    // pin synchronisers, a change counts once stages two and three agree
    logic [NPIN-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, flt_q, flt_d;
    dioim_pins_t flt;

    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_filt
            always_comb begin
                flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            flt_q <= flt_d;
        end
    end

    assign flt = dioim_pins_t'(flt_q);

    // output image capture, only defined bits are taken
    logic [7:0] dig_wr;
    logic [1:0] ack_q, ack_d;
    dioim_outs_t outs_q, outs_d;
    logic [DOB-1:0] ana_out_q, ana_out_d;

    always_comb begin
        dig_wr = out_image[DOB +: 8] & OUT_DEFINED_MASK; // R9 R14 R4
        ack_d = ack_q;
        outs_d = outs_q;
        ana_out_d = ana_out_q;
        if (out_wr) begin
            ack_d = dig_wr[OUT_ACK_POS +: 2]; // R4
            outs_d.single_out = dig_wr[OUT_SINGLE_POS]; // R11 R8
            outs_d.dual_out = dig_wr[OUT_DUAL_POS +: 2]; // R12 R8
            ana_out_d = out_image[DOB-1:0]; // R9
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= {2{RST_ACK}};
            outs_q <= '{single_out: RST_OUT_LEVEL, dual_out: {2{RST_OUT_LEVEL}}};
            ana_out_q <= '0;
        end else begin
            ack_q <= ack_d;
            outs_q <= outs_d;
            ana_out_q <= ana_out_d;
        end
    end

    assign outs = outs_q;
    assign ana_out_data = ana_out_q;

    // per channel fault handling of the diagnostic input module
    dioim_ch_t st_q [2];
    dioim_ch_t st_d [2];

    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            always_comb begin
                st_d[gi] = st_q[gi];
                case (st_q[gi])
                    CH_ACTIVE: begin
                        if (flt.diag_fault[gi]) begin
                            st_d[gi] = CH_FAULT; // R2
                        end
                    end
                    CH_FAULT: begin
                        if (!flt.diag_fault[gi]) begin
                            st_d[gi] = CH_LOCKED; // R3
                        end
                    end
                    CH_LOCKED: begin
                        if (flt.diag_fault[gi]) begin
                            st_d[gi] = CH_FAULT; // R2
                        end else if (ack_q[gi]) begin
                            st_d[gi] = CH_ACTIVE; // R3
                        end
                    end
                    default: begin
                        st_d[gi] = CH_FAULT;
                    end
                endcase
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    st_q[gi] <= CH_ACTIVE;
                end else begin
                    st_q[gi] <= st_d[gi];
                end
            end

            chk_fault_flag_set: assert property ( // R2
                @(posedge core_clk) disable iff (!rst_n)
                (st_q[gi] == CH_ACTIVE && flt.diag_fault[gi])
                |-> ##2 in_image[DIB + IN_DIAG_FAULT_POS + gi])
                else $error("fault flag not set two cycles after fault");

            chk_locked_hold: assert property ( // R3
                @(posedge core_clk) disable iff (!rst_n)
                (st_q[gi] == CH_LOCKED && !ack_q[gi] && !flt.diag_fault[gi])
                |=> st_q[gi] == CH_LOCKED ##1 !in_image[DIB + IN_DIAG_DATA_POS + gi])
                else $error("channel left lock without acknowledge");

            chk_ack_reactivate: assert property ( // R3
                @(posedge core_clk) disable iff (!rst_n)
                (st_q[gi] == CH_LOCKED && ack_q[gi] && !flt.diag_fault[gi])
                |=> st_q[gi] == CH_ACTIVE ##1 !in_image[DIB + IN_DIAG_FAULT_POS + gi])
                else $error("acknowledge did not re-activate channel");

            chk_diag_state_map: assert property ( // R1
                @(posedge core_clk) disable iff (!rst_n)
                ##1 in_image[DIB + IN_DIAG_DATA_POS + gi]
                == ($past(flt.diag_state[gi]) && $past(st_q[gi]) == CH_ACTIVE))
                else $error("channel state bit wrong");

            chk_fault_needs_pin: assert property ( // R2
                @(posedge core_clk) disable iff (!rst_n)
                st_q[gi] == CH_FAULT |-> $past(flt.diag_fault[gi]))
                else $error("fault state without a fault");

            chk_fault_exit: assert property ( // R3
                @(posedge core_clk) disable iff (!rst_n)
                (st_q[gi] == CH_FAULT && !flt.diag_fault[gi]) |=> st_q[gi] == CH_LOCKED)
                else $error("cleared fault did not lock the channel");

            chk_no_lock_skip: assert property ( // R3
                @(posedge core_clk) disable iff (!rst_n)
                st_q[gi] == CH_FAULT |=> st_q[gi] != CH_ACTIVE)
                else $error("channel re-activated straight from fault");

            chk_flag_while_locked: assert property ( // R3
                @(posedge core_clk) disable iff (!rst_n)
                st_q[gi] == CH_LOCKED |=> in_image[DIB + IN_DIAG_FAULT_POS + gi])
                else $error("fault flag dropped while channel locked");
        end
    endgenerate

    // input image assembly
    logic [DIG_IN_BYTES*8-1:0] din;
    logic [IMG_IN_W-1:0] in_image_q, in_image_d;

    always_comb begin
        din = '0; // R14
        for (int c = 0; c < 2; c++) begin
            din[IN_DIAG_DATA_POS + c] = flt.diag_state[c] && (st_q[c] == CH_ACTIVE); // R1 R3
            din[IN_DIAG_FAULT_POS + c] = (st_q[c] != CH_ACTIVE); // R1 R2
        end
        din[IN_QUAD_POS +: 4] = flt.quad_in; // R6
        din[IN_OCT_POS +: 8] = flt.oct_in; // R7
        din[IN_DUAL_POS +: 2] = flt.dual_in;
        din[IN_MANUAL_POS] = flt.manual; // R11
        in_image_d = {din, ana_in_data}; // R13
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_image_q <= '0;
        end else begin
            in_image_q <= in_image_d;
        end
    end

    assign in_image = in_image_q;

    // object instance counts
    logic [7:0] inst_in_q, inst_out_q, inst_in_d, inst_out_d;

    always_comb begin
        inst_in_d = INST_IN_TOTAL; // R5 R6 R7 R11
        inst_out_d = INST_OUT_TOTAL; // R5 R10 R11 R12
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inst_in_q <= INST_IN_TOTAL;
            inst_out_q <= INST_OUT_TOTAL;
        end else begin
            inst_in_q <= inst_in_d;
            inst_out_q <= inst_out_d;
        end
    end

    assign inst_in_cnt = inst_in_q;
    assign inst_out_cnt = inst_out_q;

    chk_inst_counts: assert property ( // R5
        @(posedge core_clk) disable iff (!rst_n)
        inst_in_cnt == 8'h14 && inst_out_cnt == 8'h08)
        else $error("object instance counts wrong");

    chk_quad_map: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_n)
        ##1 in_image[DIB + IN_QUAD_POS +: 4] == $past(flt.quad_in))
        else $error("four channel input map wrong");

    chk_oct_map: assert property ( // R7
        @(posedge core_clk) disable iff (!rst_n)
        ##1 in_image[DIB + IN_OCT_POS +: 8] == $past(flt.oct_in))
        else $error("eight channel input map wrong");

    chk_ack_map: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_n)
        out_wr |=> ack_q == $past(out_image[DOB + OUT_ACK_POS +: 2]))
        else $error("acknowledge bits not taken from bits 2 and 3");

    chk_dual_out_map: assert property ( // R12
        @(posedge core_clk) disable iff (!rst_n)
        out_wr |=> outs.dual_out == $past(out_image[DOB + OUT_DUAL_POS +: 2]))
        else $error("two channel output map wrong");

    chk_single_out_hold: assert property ( // R8
        @(posedge core_clk) disable iff (!rst_n)
        !out_wr |=> $stable(outs.single_out) && $stable(outs.dual_out))
        else $error("output changed without a write");

    chk_undef_zero: assert property ( // R14
        @(posedge core_clk) disable iff (!rst_n)
        in_image[DIB + IN_MANUAL_POS + 1] == 1'b0 && in_image[IMG_IN_W-1 -: 4] == 4'h0)
        else $error("undefined input bit not zero");

    chk_analog_first: assert property ( // R13
        @(posedge core_clk) disable iff (!rst_n)
        ##1 in_image[DIB-1:0] == $past(ana_in_data))
        else $error("analog input data not at the image start");

    chk_ana_out_first: assert property ( // R9
        @(posedge core_clk) disable iff (!rst_n)
        out_wr |=> ana_out_data == $past(out_image[DOB-1:0]))
        else $error("analog output data not at the image start");

    chk_manual_map: assert property ( // R11
        @(posedge core_clk) disable iff (!rst_n)
        ##1 in_image[DIB + IN_MANUAL_POS] == $past(flt.manual))
        else $error("manual status bit wrong");

    chk_dual_in_map: assert property ( // R13
        @(posedge core_clk) disable iff (!rst_n)
        ##1 in_image[DIB + IN_DUAL_POS +: 2] == $past(flt.dual_in))
        else $error("two channel input map wrong");

    chk_single_out_map: assert property ( // R11
        @(posedge core_clk) disable iff (!rst_n)
        out_wr |=> outs.single_out == $past(out_image[DOB + OUT_SINGLE_POS]))
        else $error("single output not taken from its bit");

    chk_ack_hold: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_n)
        !out_wr |=> $stable(ack_q))
        else $error("acknowledge changed without a write");

    chk_ana_out_hold: assert property ( // R9
        @(posedge core_clk) disable iff (!rst_n)
        !out_wr |=> $stable(ana_out_data))
        else $error("analog output changed without a write");
endmodule : dioim_map

// *** rtl/dioim_pkg.sv ***
// constants, types and layout of the digital process image map
// Overview of operation
// R1: the diagnostic input module puts channel 1 and 2 states in input bits 0 and 1 and their fault flags in bits 2 and 3.
// R2: a channel fault flag is set in the input image whenever that channel sees a fault.
// R3: after a fault clears the channel stays inactive until its acknowledge bit is set, then it is re-activated.
// R4: output bits 2 and 3 of the diagnostic input module acknowledge channels 1 and 2, and bits 0 and 1 are zero.
// R5: the diagnostic input module counts four discrete input and four discrete output instances.
// R6: the four channel input module maps channels 1 to 4 onto input bits 0 to 3 and counts four input instances.
// R7: the eight channel input module maps channels 1 to 8 onto input bits 0 to 7 and counts eight input instances.
// R8: each digital output channel takes one output image bit that drives it directly.
// R9: digital output bits follow all analog output data in the output image, packed into bytes.
// R10: each digital output channel counts one discrete output instance.
// R11: the single output module reports manual operation in input bit 0, is driven by output bit 0, leaves bit 1 unused and counts two instances per class.
// R12: the plain two channel output module drives channels 1 and 2 from output bits 0 and 1 and counts two output instances.
// R13: digital input bits follow all analog input data in the input image, packed into bytes.
// R14: undefined input image bits read zero and writes to undefined output image bits are ignored.
package dioim_pkg;
    localparam int DIG_IN_BYTES = 3;
    localparam int DIG_OUT_BYTES = 1;
    // input image bit positions inside the digital area
    localparam int IN_DIAG_DATA_POS = 0;
    localparam int IN_DIAG_FAULT_POS = 2;
    localparam int IN_QUAD_POS = 4;
    localparam int IN_OCT_POS = 8;
    localparam int IN_DUAL_POS = 16;
    localparam int IN_MANUAL_POS = 18;
    // output image bit positions inside the digital area
    localparam int OUT_DIAG_ZERO_POS = 0;
    localparam int OUT_ACK_POS = 2;
    localparam int OUT_SINGLE_POS = 4;
    localparam int OUT_DUAL_POS = 6;
    localparam logic [7:0] OUT_DEFINED_MASK = 8'hdc;
    // object instance counts per module
    localparam logic [7:0] INST_DIAG_IN = 8'h04;
    localparam logic [7:0] INST_DIAG_OUT = 8'h04;
    localparam logic [7:0] INST_QUAD_IN = 8'h04;
    localparam logic [7:0] INST_OCT_IN = 8'h08;
    localparam logic [7:0] INST_DUAL_IN = 8'h02;
    localparam logic [7:0] INST_SINGLE_IN = 8'h02;
    localparam logic [7:0] INST_SINGLE_OUT = 8'h02;
    localparam logic [7:0] INST_DUAL_OUT = 8'h02;
    localparam logic [7:0] INST_IN_TOTAL = INST_DIAG_IN + INST_QUAD_IN + INST_OCT_IN
        + INST_DUAL_IN + INST_SINGLE_IN;
    localparam logic [7:0] INST_OUT_TOTAL = INST_DIAG_OUT + INST_SINGLE_OUT + INST_DUAL_OUT;
    // reset values
    localparam logic RST_OUT_LEVEL = 1'b0;
    localparam logic RST_ACK = 1'b0;

    typedef enum logic [1:0] {CH_ACTIVE, CH_FAULT, CH_LOCKED} dioim_ch_t;

    typedef struct packed {
        logic manual;
        logic [1:0] dual_in;
        logic [7:0] oct_in;
        logic [3:0] quad_in;
        logic [1:0] diag_fault;
        logic [1:0] diag_state;
    } dioim_pins_t;

    typedef struct packed {
        logic single_out;
        logic [1:0] dual_out;
    } dioim_outs_t;
endpackage : dioim_pkg

// *** test/dioim_coupler.sv ***
// coupler model that writes the output image
module dioim_coupler (
    input wire logic core_clk,
    output logic out_wr,
    output logic [15:0] out_image
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        out_wr = 1'b0;
        out_image = 16'h0000;
    end
    // one write taken at the next rising edge; the strobe stays up until idle
    task automatic put(input logic [15:0] v);
        out_image <= {v[15:10], 2'b00, v[7:0]};
        out_wr <= 1'b1;
        @(posedge core_clk);
    endtask : put
    // released data shows the inverse of the last value
    task automatic idle();
        out_wr <= 1'b0;
        out_image <= ~out_image;
    endtask : idle
endmodule : dioim_coupler

// *** test/dioim_map_tb.sv ***
// self-checking bench for the digital process image mapper
module dioim_map_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dioim_pkg::*;
    typedef struct {int sel; logic [31:0] v; int due;} dioim_note_t;
    logic core_clk;
    logic rst_n;
    logic out_wr;
    logic [15:0] out_image;
    dioim_pins_t pins;
    logic [7:0] ana_in_data;
    logic [31:0] in_image;
    logic [7:0] ana_out_data;
    dioim_outs_t outs;
    logic [7:0] inst_in_cnt;
    logic [7:0] inst_out_cnt;
    logic [1:0] flg;
    logic [31:0] seen;
    dioim_note_t q[$];
    string names[3] = '{"in_image", "outs", "counts"};
    int cyc = 0;
    int err_total = 0;
    int cmp_count = 0;

    dioim_map #(.ANA_IN_BYTES(1), .ANA_OUT_BYTES(1)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .pins(pins), .ana_in_data(ana_in_data),
        .in_image(in_image), .out_wr(out_wr), .out_image(out_image),
        .ana_out_data(ana_out_data), .outs(outs), .inst_in_cnt(inst_in_cnt),
        .inst_out_cnt(inst_out_cnt));
    dioim_coupler cpl (.core_clk(core_clk), .out_wr(out_wr), .out_image(out_image));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask : check

    task automatic note(input int sel, input logic [31:0] v, input int lat);
        dioim_note_t n;
        n = '{sel, v, cyc + lat};
        q.push_back(n);
    endtask : note

    task automatic complete_run();
        if (q.size() != 0) begin
            err_total++;
        end
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // drive pins and analog input, note the image they must give once settled
    task automatic expect_in(input dioim_pins_t p, input logic [7:0] a);
        logic [23:0] d;
        pins <= p;
        ana_in_data <= a;
        d = {5'h00, p.manual, p.dual_in, p.oct_in, p.quad_in, flg, p.diag_state & ~flg};
        note(0, {d, a}, 8);
        repeat (8) @(posedge core_clk);
    endtask : expect_in

    // watcher takes the oldest note once its result is due
    always @(negedge core_clk) begin
        cyc++;
        while (q.size() > 0 && q[0].due <= cyc) begin
            seen = (q[0].sel == 0) ? in_image : (q[0].sel == 1) ?
                {21'h0, outs, ana_out_data} : {16'h0, inst_in_cnt, inst_out_cnt};
            check(names[q[0].sel], seen, q[0].v);
            void'(q.pop_front());
        end
        if (cyc > 2000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        logic [15:0] w;
        logic [31:0] e;
        dioim_pins_t p;
        rst_n = 1'b0;
        pins = '0;
        ana_in_data = 8'h00;
        flg = 2'b00;
        void'($urandom(57509));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        note(0, 32'h0, 1);
        note(1, 32'h0, 1);
        note(2, {16'h0, 8'h04 + 8'h04 + 8'h08 + 8'h02 + 8'h02, 8'h04 + 8'h02 + 8'h02}, 1);
        @(posedge core_clk);
        for (int i = 0; i < 12; i++) begin
            p = 19'($urandom) | ((i == 0) ? 19'h7ffff : 19'h00000);
            p.diag_fault = 2'b00;
            expect_in(p, 8'($urandom));
        end
        cpl.put(16'h0000);
        cpl.idle();
        for (int c = 0; c < 2; c++) begin
            p = 19'h7ffff;
            p.diag_fault = 2'b00;
            p.diag_fault[c] = 1'b1;
            flg[c] = 1'b1;
            expect_in(p, 8'h5a);
            p.diag_fault[c] = 1'b0;
            expect_in(p, 8'ha5);
            cpl.put(16'h0400 << c);
            cpl.idle();
            flg[c] = 1'b0;
            expect_in(p, 8'h3c);
            cpl.put(16'h0000);
            cpl.idle();
        end
        @(posedge core_clk);
        for (int i = 0; i < 16; i++) begin
            w = (i == 0) ? 16'hf3ff : 16'($urandom) & 16'hf3ff;
            e = {21'h0, w[12], w[15], w[14], w[7:0]};
            note(1, e, 2);
            cpl.put(w);
        end
        cpl.idle();
        note(1, e, 3);
        repeat (5) @(posedge core_clk);
        complete_run();
    end
endmodule : dioim_map_tb
